// *** inc/issh_pkg.sv ***
// Contract
// - Special-page read loads working register, flags kept.
// - File register minus working register sets flags.
// - Destination bit picks working or file register.
// - Immediate minus working register into working register.
// - Halt clears watchdog counter, prescaler, stops execution.
// - Halt sets expiry flag, clears halt flag only.
// - Nibble exchange swaps halves, flags untouched.
// - Timer0 mode load copies working register, flags kept.
`default_nettype none
package issh_pkg;
    localparam int FILE_DEPTH = 128;
    localparam int SP_DEPTH = 22;
    localparam int PRE_BITS = 8;
    localparam logic [7:0] ADDR_FILE_BASE = 8'h00;
    localparam logic [7:0] ADDR_SP_BASE = 8'h80;
    localparam logic [7:0] ADDR_WORK = 8'ha0;
    localparam logic [7:0] ADDR_STATUS = 8'ha1;
    localparam logic [7:0] ADDR_TIMER0_MODE = 8'ha2;
    localparam logic [7:0] ADDR_WATCHDOG = 8'ha3;
    localparam logic [7:0] ADDR_PRE = 8'ha4;
    localparam logic [7:0] ADDR_HALT = 8'ha5;
    localparam int ST_C = 0;
    localparam int ST_HALF = 1;
    localparam int ST_Z = 2;
    localparam int ST_HALT_N = 3;
    localparam int ST_EXPIRY_N = 4;
    localparam logic [7:0] STATUS_RST = 8'h18;
    localparam logic [7:0] WORK_RST = 8'h00;
    localparam logic [7:0] TIMER0_MODE_RST = 8'h00;
    localparam logic [7:0] WATCHDOG_RST = 8'h00;
    typedef enum logic [2:0] {
        OP_SP_READ,
        OP_REG_SUB,
        OP_IMM_SUB,
        OP_SWAP,
        OP_TIMER0_MODE_LOAD,
        OP_HALT
    } issh_op_t;
endpackage : issh_pkg
`default_nettype wire

// *** rtl/issh_alu.sv ***
`timescale 1ns/1ns
`default_nettype none
module issh_alu (
    input wire issh_pkg::issh_op_t op_in,
    input wire logic [7:0] src_in,
    input wire logic [7:0] work_in,
    output logic [7:0] result_out,
    output logic carry_out,
    output logic half_out,
    output logic zero_out
);
    logic [8:0] diff;
    logic [4:0] half_diff;

    // Subtraction is done as src + ~work + 1 so carry out is the inverse of borrow.
    always_comb
    begin
        diff = {1'b0, src_in} + {1'b0, ~work_in} + 9'h001;
        half_diff = {1'b0, src_in[3:0]} + {1'b0, ~work_in[3:0]} + 5'h01;
        if (op_in == issh_pkg::OP_SWAP)
        begin
            result_out = {src_in[3:0], src_in[7:4]};
        end
        else
        begin
            result_out = diff[7:0];
        end
        carry_out = diff[8];
        half_out = half_diff[4];
        zero_out = (diff[7:0] == 8'h00);
    end
endmodule : issh_alu
`default_nettype wire

// *** rtl/issh_slice.sv ***
// Strobed register access and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
module issh_slice #(
    parameter int FILE_DEPTH = issh_pkg::FILE_DEPTH,
    parameter int SP_DEPTH = issh_pkg::SP_DEPTH,
    parameter int PRE_BITS = issh_pkg::PRE_BITS
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic op_valid_in,
    input wire issh_pkg::issh_op_t op_in,
    input wire logic [6:0] op_addr_in,
    input wire logic op_dest_in,
    input wire logic [7:0] op_imm_in,
    output logic op_ready_out,
    input wire logic wake_in,
    input wire logic watchdog_en_in,
    output logic [7:0] work_out,
    output logic [7:0] status_out,
    output logic [7:0] timer0_mode_out,
    output logic halted_out
);
    if (FILE_DEPTH < 1 || FILE_DEPTH > 128 || SP_DEPTH < 1 || SP_DEPTH > 32
        || PRE_BITS < 1 || PRE_BITS > 8)
    begin : g_bad_param
        $error("issh_slice parameter out of range");
    end

    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic [7:0] file_mem [FILE_DEPTH];
    logic [7:0] sp_mem [SP_DEPTH];
    logic [7:0] work_reg, work_next;
    logic [7:0] status_reg, status_next;
    logic [7:0] timer0_mode_reg, timer0_mode_next;
    logic [7:0] watchdog_counter_reg, watchdog_counter_next;
    logic [PRE_BITS-1:0] pre_reg, pre_next;
    logic halted_reg, halted_next;
    logic [7:0] rdata_reg, rdata_next;
    logic op_take;
    logic [7:0] op_src;
    logic op_file_we;
    logic bus_file_we;
    logic bus_sp_we;
    logic [7:0] alu_result;
    logic alu_carry, alu_half, alu_zero;

    function automatic logic is_file(input logic [7:0] a);
        is_file = (a >= issh_pkg::ADDR_FILE_BASE)
            && (32'(a) < 32'(issh_pkg::ADDR_FILE_BASE) + FILE_DEPTH);
    endfunction : is_file

    function automatic logic is_sp(input logic [7:0] a);
        is_sp = (a >= issh_pkg::ADDR_SP_BASE)
            && (32'(a) < 32'(issh_pkg::ADDR_SP_BASE) + SP_DEPTH);
    endfunction : is_sp

    // The reset is released through two flops so that its removal is clean.
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            rst_sync_reg <= 2'h0;
        end
        else
        begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // Execution stops while halted; a wake or a bus write with bit 0 clear to the halt register brings it back.
    assign op_ready_out = !halted_reg;
    assign op_take = op_valid_in && !halted_reg;

    assign op_src = (op_in == issh_pkg::OP_IMM_SUB) ? op_imm_in
        : (32'(op_addr_in) < FILE_DEPTH) ? file_mem[op_addr_in] : 8'h00;

    issh_alu u_alu (
        .op_in(op_in),
        .src_in(op_src),
        .work_in(work_reg),
        .result_out(alu_result),
        .carry_out(alu_carry),
        .half_out(alu_half),
        .zero_out(alu_zero)
    );

    assign bus_file_we = wr_in && is_file(addr_in);
    assign bus_sp_we = wr_in && is_sp(addr_in);

    // Bus writes come first so an instruction in the same cycle overrides them.
    always_comb
    begin
        work_next = work_reg;
        status_next = status_reg;
        timer0_mode_next = timer0_mode_reg;
        watchdog_counter_next = watchdog_counter_reg;
        pre_next = pre_reg;
        halted_next = halted_reg;
        op_file_we = 1'b0;
        rdata_next = 8'h00;
        if (watchdog_en_in && !halted_reg)
        begin
            pre_next = pre_reg + 1'b1;
            if (&pre_reg)
            begin
                watchdog_counter_next = watchdog_counter_reg + 8'h01;
            end
        end
        if (wr_in)
        begin
            unique case (addr_in)
                issh_pkg::ADDR_WORK: work_next = wdata_in;
                issh_pkg::ADDR_STATUS: status_next = wdata_in;
                issh_pkg::ADDR_TIMER0_MODE: timer0_mode_next = wdata_in;
                issh_pkg::ADDR_WATCHDOG: watchdog_counter_next = wdata_in;
                issh_pkg::ADDR_PRE: pre_next = wdata_in[PRE_BITS-1:0];
                issh_pkg::ADDR_HALT: halted_next = wdata_in[0];
                default: ;
            endcase
        end
        if (halted_reg && wake_in)
        begin
            halted_next = 1'b0;
        end
        if (op_take)
        begin
            unique case (op_in)
                issh_pkg::OP_SP_READ: work_next = (32'(op_addr_in) < SP_DEPTH)
                    ? sp_mem[op_addr_in[4:0]] : work_reg;
                issh_pkg::OP_REG_SUB, issh_pkg::OP_IMM_SUB:
                begin
                    if (op_in == issh_pkg::OP_REG_SUB && op_dest_in)
                    begin
                        op_file_we = (32'(op_addr_in) < FILE_DEPTH);
                    end
                    else
                    begin
                        work_next = alu_result;
                    end
                    status_next[issh_pkg::ST_C] = alu_carry;
                    status_next[issh_pkg::ST_HALF] = alu_half;
                    status_next[issh_pkg::ST_Z] = alu_zero;
                end
                issh_pkg::OP_SWAP:
                begin
                    if (op_dest_in)
                    begin
                        op_file_we = (32'(op_addr_in) < FILE_DEPTH);
                    end
                    else
                    begin
                        work_next = alu_result;
                    end
                end
                issh_pkg::OP_TIMER0_MODE_LOAD: timer0_mode_next = work_reg;
                issh_pkg::OP_HALT:
                begin
                    watchdog_counter_next = issh_pkg::WATCHDOG_RST;
                    pre_next = '0;
                    halted_next = 1'b1;
                    status_next[issh_pkg::ST_EXPIRY_N] = 1'b1;
                    status_next[issh_pkg::ST_HALT_N] = 1'b0;
                end
                default: ;
            endcase
        end
        if (rd_in)
        begin
            if (is_file(addr_in))
            begin
                rdata_next = file_mem[addr_in[6:0]];
            end
            else if (is_sp(addr_in))
            begin
                rdata_next = sp_mem[addr_in[4:0]];
            end
            else
            begin
                unique case (addr_in)
                    issh_pkg::ADDR_WORK: rdata_next = work_reg;
                    issh_pkg::ADDR_STATUS: rdata_next = status_reg;
                    issh_pkg::ADDR_TIMER0_MODE: rdata_next = timer0_mode_reg;
                    issh_pkg::ADDR_WATCHDOG: rdata_next = watchdog_counter_reg;
                    issh_pkg::ADDR_PRE: rdata_next = 8'(pre_reg);
                    issh_pkg::ADDR_HALT: rdata_next = {7'h00, halted_reg};
                    default: rdata_next = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            work_reg <= issh_pkg::WORK_RST;
            status_reg <= issh_pkg::STATUS_RST;
            timer0_mode_reg <= issh_pkg::TIMER0_MODE_RST;
            watchdog_counter_reg <= issh_pkg::WATCHDOG_RST;
            pre_reg <= '0;
            halted_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end
        else
        begin
            work_reg <= work_next;
            status_reg <= status_next;
            timer0_mode_reg <= timer0_mode_next;
            watchdog_counter_reg <= watchdog_counter_next;
            pre_reg <= pre_next;
            halted_reg <= halted_next;
            rdata_reg <= rdata_next;
        end
    end

    // Storage has no reset; software is expected to initialise it.
    always_ff @(posedge clk_in)
    begin
        if (bus_file_we)
        begin
            file_mem[addr_in[6:0]] <= wdata_in;
        end
        if (op_file_we)
        begin
            file_mem[op_addr_in] <= alu_result;
        end
        if (bus_sp_we)
        begin
            sp_mem[addr_in[4:0]] <= wdata_in;
        end
    end

    assign rdata_out = rdata_reg;
    assign work_out = work_reg;
    assign status_out = status_reg;
    assign timer0_mode_out = timer0_mode_reg;
    assign halted_out = halted_reg;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n);

    AST_SP_READ: assert property (
        op_take && op_in == issh_pkg::OP_SP_READ && op_addr_in < 7'(SP_DEPTH) && !wr_in
        |=> work_reg == $past(sp_mem[op_addr_in[4:0]]) && status_reg == $past(status_reg))
        else $error("special-page read did not load the working register");
    AST_REG_SUB: assert property (
        op_take && op_in == issh_pkg::OP_REG_SUB && !op_dest_in
        |=> work_reg == 8'($past(op_src) - $past(work_reg))
            && status_reg[issh_pkg::ST_HALF]
               == ($past(op_src[3:0]) >= $past(work_reg[3:0])))
        else $error("register subtract result or half carry wrong");
    AST_DEST: assert property (
        op_take && op_in == issh_pkg::OP_SWAP && op_dest_in && !wr_in
        |=> work_reg == $past(work_reg)
            && file_mem[$past(op_addr_in)] == {$past(op_src[3:0]), $past(op_src[7:4])})
        else $error("destination bit one did not write the file register");
    AST_IMM_SUB: assert property (
        op_take && op_in == issh_pkg::OP_IMM_SUB
        |=> work_reg == 8'($past(op_imm_in) - $past(work_reg)))
        else $error("immediate subtract result wrong");
    AST_HALT_CLR: assert property (
        op_take && op_in == issh_pkg::OP_HALT && !wr_in
        |=> watchdog_counter_reg == 8'h00 && pre_reg == '0 && halted_reg && !op_ready_out)
        else $error("halt did not clear the watchdog or stop execution");
    AST_HALT_FLAGS: assert property (
        op_take && op_in == issh_pkg::OP_HALT && !wr_in
        |=> status_reg[issh_pkg::ST_EXPIRY_N] && !status_reg[issh_pkg::ST_HALT_N]
            && status_reg[2:0] == $past(status_reg[2:0]))
        else $error("halt flags wrong");
    AST_SWAP: assert property (
        op_take && op_in == issh_pkg::OP_SWAP && !op_dest_in && !wr_in
        |=> work_reg == {$past(op_src[3:0]), $past(op_src[7:4])}
            && status_reg == $past(status_reg))
        else $error("nibble exchange wrong");
    AST_TIMER0_MODE: assert property (
        op_take && op_in == issh_pkg::OP_TIMER0_MODE_LOAD && !wr_in
        |=> timer0_mode_reg == $past(work_reg) && status_reg == $past(status_reg))
        else $error("timer0 mode load wrong");
    AST_CARRY: assert property (
        op_take && op_in == issh_pkg::OP_IMM_SUB
        |=> status_reg[issh_pkg::ST_C] == ($past(op_imm_in) >= $past(work_reg))
            && status_reg[issh_pkg::ST_Z] == (work_reg == 8'h00))
        else $error("carry or zero flag wrong after subtract");
endmodule : issh_slice
`default_nettype wire

// *** tb/tb_issh_slice.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_issh_slice;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic op_valid_in = 1'b0;
    issh_pkg::issh_op_t op_in = issh_pkg::OP_SWAP;
    logic [6:0] op_addr_in = 7'h00;
    logic op_dest_in = 1'b0;
    logic [7:0] op_imm_in = 8'h00;
    logic wake_in = 1'b0;
    logic watchdog_en_in = 1'b0;
    logic [7:0] rdata_out;
    logic [7:0] work_out;
    logic [7:0] status_out;
    logic [7:0] timer0_mode_out;
    logic op_ready_out;
    logic halted_out;
    logic [7:0] rd_val;
    logic [7:0] ra [4] = '{8'h05, 8'h06, 8'h05, 8'h10};
    logic [7:0] wa [4] = '{8'h06, 8'h05, 8'h05, 8'h01};
    int bad_count = 0;
    int tests_run = 0;

    always #10 clk_in = ~clk_in;

    // A short prescaler lets the watchdog counter move within a few cycles.
    issh_slice #(.FILE_DEPTH(128), .SP_DEPTH(22), .PRE_BITS(2)) i_dut (
        .clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .op_valid_in(op_valid_in),
        .op_in(op_in), .op_addr_in(op_addr_in), .op_dest_in(op_dest_in),
        .op_imm_in(op_imm_in), .op_ready_out(op_ready_out), .wake_in(wake_in),
        .watchdog_en_in(watchdog_en_in), .work_out(work_out), .status_out(status_out),
        .timer0_mode_out(timer0_mode_out), .halted_out(halted_out)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run

    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
        #1;
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        d = rdata_out;
    endtask : bus_rd

    // Calling op_start twice in a row issues back-to-back instructions.
    task automatic op_start(input issh_pkg::issh_op_t o, input logic [6:0] a,
                            input logic d, input logic [7:0] i);
        @(posedge clk_in);
        op_valid_in <= 1'b1;
        op_in <= o;
        op_addr_in <= a;
        op_dest_in <= d;
        op_imm_in <= i;
    endtask : op_start

    task automatic op_end;
        @(posedge clk_in);
        op_valid_in <= 1'b0;
        #1;
    endtask : op_end

    function automatic logic [7:0] sub_st(input logic [7:0] a, input logic [7:0] b,
                                          input logic [7:0] st);
        logic [7:0] r;
        r = a - b;
        sub_st = st;
        sub_st[issh_pkg::ST_C] = (a >= b);
        sub_st[issh_pkg::ST_HALF] = (a[3:0] >= b[3:0]);
        sub_st[issh_pkg::ST_Z] = (r == 8'h00);
    endfunction : sub_st

    initial
    begin
        #100000;
        bad_count++;
        complete_run;
    end

    initial
    begin
        repeat (20) @(posedge clk_in);
        resetn_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        #1;
        check(status_out, issh_pkg::STATUS_RST);
        check({7'h00, halted_out}, 8'h00);
        check(timer0_mode_out, issh_pkg::TIMER0_MODE_RST);
        bus_rd(8'hff, rd_val);
        check(rd_val, 8'h00);
        bus_wr(8'h95, 8'h55);
        bus_wr(issh_pkg::ADDR_WORK, 8'haa);
        bus_wr(issh_pkg::ADDR_STATUS, 8'h1f);
        op_start(issh_pkg::OP_SP_READ, 7'd21, 1'b0, 8'h00);
        op_end;
        check(work_out, 8'h55);
        check(status_out, 8'h1f);
        op_start(issh_pkg::OP_SP_READ, 7'd22, 1'b0, 8'h00);
        op_end;
        check(work_out, 8'h55);
        for (int k = 0; k < 4; k++)
        begin
            bus_wr(8'(k), ra[k]);
            bus_wr(issh_pkg::ADDR_WORK, wa[k]);
            bus_wr(issh_pkg::ADDR_STATUS, 8'h18);
            op_start(issh_pkg::OP_REG_SUB, 7'(k), k[0], 8'h00);
            op_end;
            check(status_out, sub_st(ra[k], wa[k], 8'h18));
            bus_rd(8'(k), rd_val);
            check(k[0] ? rd_val : work_out, ra[k] - wa[k]);
            check(k[0] ? work_out : rd_val, k[0] ? wa[k] : ra[k]);
            bus_wr(issh_pkg::ADDR_WORK, wa[k]);
            bus_wr(issh_pkg::ADDR_STATUS, 8'h07);
            op_start(issh_pkg::OP_IMM_SUB, 7'h00, 1'b0, ra[k]);
            op_end;
            check(work_out, ra[k] - wa[k]);
            check(status_out, sub_st(ra[k], wa[k], 8'h07));
        end
        bus_wr(8'h10, 8'ha5);
        bus_wr(issh_pkg::ADDR_STATUS, 8'h0a);
        op_start(issh_pkg::OP_SWAP, 7'h10, 1'b1, 8'h00);
        op_end;
        bus_rd(8'h10, rd_val);
        check(rd_val, 8'h5a);
        op_start(issh_pkg::OP_SWAP, 7'h10, 1'b0, 8'h00);
        op_end;
        check(work_out, 8'ha5);
        check(status_out, 8'h0a);
        bus_wr(issh_pkg::ADDR_WORK, 8'h05);
        op_start(issh_pkg::OP_IMM_SUB, 7'h00, 1'b0, 8'h06);
        op_start(issh_pkg::OP_TIMER0_MODE_LOAD, 7'h00, 1'b0, 8'h00);
        op_end;
        check(timer0_mode_out, 8'h01);
        check(status_out, sub_st(8'h06, 8'h05, 8'h0a));
        bus_rd(issh_pkg::ADDR_TIMER0_MODE, rd_val);
        check(rd_val, 8'h01);
        bus_rd(issh_pkg::ADDR_WORK, rd_val);
        check(rd_val, 8'h01);
        bus_rd(issh_pkg::ADDR_STATUS, rd_val);
        check(rd_val, sub_st(8'h06, 8'h05, 8'h0a));
        @(posedge clk_in);
        watchdog_en_in <= 1'b1;
        repeat (12) @(posedge clk_in);
        bus_rd(issh_pkg::ADDR_WATCHDOG, rd_val);
        check({7'h00, rd_val !== 8'h00}, 8'h01);
        bus_wr(issh_pkg::ADDR_STATUS, 8'h0b);
        op_start(issh_pkg::OP_HALT, 7'h00, 1'b0, 8'h00);
        op_end;
        check({6'h00, halted_out, op_ready_out}, 8'h02);
        check(status_out, 8'h13);
        repeat (8) @(posedge clk_in);
        bus_rd(issh_pkg::ADDR_WATCHDOG, rd_val);
        check(rd_val, 8'h00);
        bus_rd(issh_pkg::ADDR_PRE, rd_val);
        check(rd_val, 8'h00);
        op_start(issh_pkg::OP_IMM_SUB, 7'h00, 1'b0, 8'h80);
        op_end;
        check(work_out, 8'h01);
        @(posedge clk_in);
        wake_in <= 1'b1;
        @(posedge clk_in);
        wake_in <= 1'b0;
        #1;
        check({6'h00, halted_out, op_ready_out}, 8'h01);
        bus_wr(issh_pkg::ADDR_HALT, 8'h01);
        check({7'h00, halted_out}, 8'h01);
        bus_wr(issh_pkg::ADDR_HALT, 8'h00);
        check({7'h00, halted_out}, 8'h00);
        complete_run;
    end
endmodule : tb_issh_slice
`default_nettype wire
